// file: ast_top.sv
// converter sequencer: axi4-lite registers, conversion control, calibration table
`timescale 1ns/1ps
module ast_top
	import ast_pkg::*;
#(
	// calibration constants held in option memory (values arbitrary)
	parameter logic [15:0] CAL_SLOPE = 16'h0ab9,
	parameter logic [11:0] CAL_TOS   = 12'h407
) (
	// clock and reset
	input  wire logic              aclk,
	input  wire logic              aresetn,
	// write address channel
	input  wire logic [AST_AW-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	// write data channel
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	// write response channel
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	// read address channel
	input  wire logic [AST_AW-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	// read data channel
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	// analog macro
	output ast_analog_t            ana_ctrl,
	input  wire logic              comp_in,
	// interrupt to cpu
	output logic                   conv_irq
);

	// ------------------------------------------------------------
	// address decode
	// ------------------------------------------------------------
	function automatic ast_reg_t reg_of(input logic [AST_AW-1:0] a);
		if (a == AST_OFF_CTRL1) begin
			return AST_R_CTRL1;
		end else if (a == AST_OFF_CTRL2) begin
			return AST_R_CTRL2;
		end else if (a == AST_OFF_RESH) begin
			return AST_R_RESH;
		end else if (a == AST_OFF_RESL) begin
			return AST_R_RESL;
		end else if (a == AST_OFF_IRQ) begin
			return AST_R_IRQ;
		end else if (a == AST_OFF_OMAP) begin
			return AST_R_OMAP;
		end else if (a == AST_OFF_TADDR) begin
			return AST_R_TADDR;
		end else if (a == AST_OFF_TDATA) begin
			return AST_R_TDATA;
		end else begin
			return AST_R_NONE;
		end
	endfunction

	// calibration byte seen through the last program memory page
	function automatic logic [7:0] cal_byte(input logic en, input logic [11:0] a);
		if (!en) begin
			return 8'h00;
		end else if (a == AST_CAL_SLOPE_H) begin
			return CAL_SLOPE[15:8];
		end else if (a == AST_CAL_SLOPE_L) begin
			return CAL_SLOPE[7:0];
		end else if (a == AST_CAL_TOS_H) begin
			return CAL_TOS[11:4];
		end else if (a == AST_CAL_TOS_L) begin
			return {4'h0, CAL_TOS[3:0]};
		end else begin
			return 8'h00;
		end
	endfunction

	// ------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------
	logic                 awready_q;
	logic                 wready_q;
	logic                 bvalid_q;
	logic [1:0]           bresp_q;
	logic [AST_AW-1:0]    awaddr_q;
	logic [31:0]          wdata_q;
	logic [3:0]           wstrb_q;
	logic                 arready_q;
	logic                 rvalid_q;
	logic [1:0]           rresp_q;
	logic [31:0]          rdata_q;
	logic                 wr_fire;
	logic                 ar_hs;
	ast_reg_t             wr_reg;
	logic                 wr_lo;

	logic                 start_q;
	logic                 start_prev_q;
	logic                 pwr_q;
	logic [3:0]           chan_q;
	logic [2:0]           src_q;
	logic [1:0]           ref_q;
	logic [2:0]           div_q;
	logic                 gie_q;
	logic                 ie_q;
	logic                 flag_q;
	logic                 omap_q;
	logic [11:0]          taddr_q;
	logic [AST_RES_W-1:0] res_q;
	logic                 irq_q;

	ast_state_t           state_q;
	logic [5:0]           samp_need_q;
	logic [5:0]           samp_cnt_q;
	logic [1:0]           settle_q;
	logic                 comp_s1_q;
	logic                 comp_s2_q;
	logic                 tick;
	logic                 sar_load;
	logic                 sar_step;
	logic [AST_RES_W-1:0] sar_code;
	logic                 sar_done;
	logic                 start_fall;
	logic                 abort;
	logic                 busy;
	ast_analog_t          ana_q;

	// ------------------------------------------------------------
	// axi4-lite write path
	// ------------------------------------------------------------
	assign wr_fire = !awready_q && !wready_q && !bvalid_q;
	assign wr_reg  = reg_of(awaddr_q);
	assign wr_lo   = wr_fire && wstrb_q[0];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_q <= 1'b1;
			awaddr_q  <= '0;
		end else if (awready_q && s_axi_awvalid) begin
			awready_q <= 1'b0;
			awaddr_q  <= s_axi_awaddr;
		end else if (bvalid_q && s_axi_bready) begin
			awready_q <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wready_q <= 1'b1;
			wdata_q  <= 32'h0000_0000;
			wstrb_q  <= 4'h0;
		end else if (wready_q && s_axi_wvalid) begin
			wready_q <= 1'b0;
			wdata_q  <= s_axi_wdata;
			wstrb_q  <= s_axi_wstrb;
		end else if (bvalid_q && s_axi_bready) begin
			wready_q <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_q <= 1'b0;
			bresp_q  <= AST_RESP_OKAY;
		end else if (wr_fire) begin
			bvalid_q <= 1'b1;
			bresp_q  <= (wr_reg == AST_R_NONE) ? AST_RESP_SLVERR : AST_RESP_OKAY;
		end else if (s_axi_bready) begin
			bvalid_q <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// control registers
	// ------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			start_q <= AST_RST_CTRL1[AST_C1_START];
			pwr_q   <= AST_RST_CTRL1[AST_C1_PWR];
			chan_q  <= AST_RST_CTRL1[3:0];
		end else if (wr_lo && wr_reg == AST_R_CTRL1) begin
			start_q <= wdata_q[AST_C1_START];
			pwr_q   <= wdata_q[AST_C1_PWR];
			chan_q  <= wdata_q[3:0];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			src_q <= AST_RST_CTRL2[AST_C2_SRC +: 3];
			ref_q <= AST_RST_CTRL2[AST_C2_REF +: 2];
			div_q <= AST_RST_CTRL2[AST_C2_DIV +: 3];
		end else if (wr_lo && wr_reg == AST_R_CTRL2) begin
			src_q <= wdata_q[AST_C2_SRC +: 3];
			ref_q <= wdata_q[AST_C2_REF +: 2];
			div_q <= wdata_q[AST_C2_DIV +: 3];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			gie_q <= 1'b0;
			ie_q  <= 1'b0;
		end else if (wr_lo && wr_reg == AST_R_IRQ) begin
			gie_q <= wdata_q[AST_IRQ_GIE];
			ie_q  <= wdata_q[AST_IRQ_IE];
		end
	end

	// completion sets the flag; a clearing write in the same cycle loses
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			flag_q <= 1'b0;
		end else if (sar_done && state_q == AST_CONVERT && !abort) begin
			flag_q <= 1'b1;
		end else if (wr_lo && wr_reg == AST_R_IRQ && !wdata_q[AST_IRQ_FLAG]) begin
			flag_q <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			omap_q  <= 1'b0;
			taddr_q <= AST_RST_TADDR;
		end else begin
			if (wr_lo && wr_reg == AST_R_OMAP) begin
				omap_q <= wdata_q[0];
			end
			if (wr_lo && wr_reg == AST_R_TADDR) begin
				taddr_q[7:0] <= wdata_q[7:0];
			end
			if (wr_fire && wstrb_q[1] && wr_reg == AST_R_TADDR) begin
				taddr_q[11:8] <= wdata_q[11:8];
			end
		end
	end

	// ------------------------------------------------------------
	// conversion sequencer
	// ------------------------------------------------------------
	assign start_fall = start_prev_q && !start_q;
	assign abort      = start_q || !pwr_q;
	assign busy       = (state_q != AST_IDLE);
	assign sar_load   = (state_q == AST_SAMPLE) && !abort && tick
		&& (samp_cnt_q == samp_need_q - 6'h01);
	assign sar_step   = (state_q == AST_CONVERT) && !abort && tick && (settle_q == 2'h0);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			start_prev_q <= 1'b0;
			comp_s1_q    <= 1'b0;
			comp_s2_q    <= 1'b0;
		end else begin
			start_prev_q <= start_q;
			comp_s1_q    <= comp_in;
			comp_s2_q    <= comp_s1_q;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_q     <= AST_IDLE;
			samp_need_q <= AST_SAMPLE_EXT;
			samp_cnt_q  <= 6'h00;
		end else begin
			case (state_q)
				AST_IDLE: begin
					if (start_fall && pwr_q) begin
						state_q     <= AST_SAMPLE;
						samp_cnt_q  <= 6'h00;
						samp_need_q <= (src_q == AST_SRC_TEMP) ? AST_SAMPLE_TEMP
							: AST_SAMPLE_EXT;
					end
				end
				AST_SAMPLE: begin
					if (abort) begin
						state_q <= AST_IDLE;
					end else if (sar_load) begin
						state_q <= AST_CONVERT;
					end else if (tick) begin
						samp_cnt_q <= samp_cnt_q + 6'h01;
					end
				end
				AST_CONVERT: begin
					if (abort || sar_done) begin
						state_q <= AST_IDLE;
					end
				end
				default: begin
					state_q <= AST_IDLE;
				end
			endcase
		end
	end

	// trial code must reach the comparator and its synchroniser before a decision
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			settle_q <= 2'h0;
		end else if (sar_load || sar_step) begin
			settle_q <= AST_SETTLE;
		end else if (settle_q != 2'h0) begin
			settle_q <= settle_q - 2'h1;
		end
	end

	// both result bytes change in the same edge
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			res_q <= 12'h000;
		end else if (sar_done && state_q == AST_CONVERT && !abort) begin
			res_q <= sar_code;
		end
	end

	ast_clkdiv u_clkdiv (
		.aclk               (aclk),
		.aresetn            (aresetn),
		.run                (busy && !abort),
		.conv_clock_divider (div_q),
		.tick_q             (tick)
	);

	ast_sar u_sar (
		.aclk    (aclk),
		.aresetn (aresetn),
		.load    (sar_load),
		.step    (sar_step),
		.comp    (comp_s2_q),
		.code_q  (sar_code),
		.done_q  (sar_done)
	);

	// ------------------------------------------------------------
	// analog controls and interrupt
	// ------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ana_q <= '0;
		end else begin
			ana_q.power               <= pwr_q;
			ana_q.sample              <= pwr_q && state_q == AST_SAMPLE && !abort;
			ana_q.ref_voltage_select  <= ref_q;
			ana_q.input_source_select <= src_q;
			ana_q.ext_channel_select  <= chan_q;
			ana_q.dac_code            <= pwr_q ? sar_code : 12'h000;
		end
	end

	assign ana_ctrl = ana_q;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= flag_q && gie_q && ie_q;
		end
	end

	assign conv_irq = irq_q;

	// ------------------------------------------------------------
	// axi4-lite read path
	// ------------------------------------------------------------
	assign ar_hs = arready_q && s_axi_arvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_q <= 1'b1;
			rvalid_q  <= 1'b0;
			rresp_q   <= AST_RESP_OKAY;
			rdata_q   <= 32'h0000_0000;
		end else if (ar_hs) begin
			arready_q <= 1'b0;
			rvalid_q  <= 1'b1;
			rresp_q   <= AST_RESP_OKAY;
			rdata_q   <= 32'h0000_0000;
			case (reg_of(s_axi_araddr))
				AST_R_CTRL1: begin
					rdata_q[7:0] <= {start_q, busy, pwr_q, 1'b0, chan_q};
				end
				AST_R_CTRL2: begin
					rdata_q[7:0] <= {src_q, ref_q, div_q};
				end
				AST_R_RESH: begin
					rdata_q[7:0] <= res_q[11:4];
				end
				AST_R_RESL: begin
					rdata_q[7:0] <= {res_q[3:0], 4'h0};
				end
				AST_R_IRQ: begin
					rdata_q[2:0] <= {flag_q, ie_q, gie_q};
				end
				AST_R_OMAP: begin
					rdata_q[0] <= omap_q;
				end
				AST_R_TADDR: begin
					rdata_q[11:0] <= taddr_q;
				end
				AST_R_TDATA: begin
					rdata_q[7:0] <= cal_byte(omap_q, taddr_q);
				end
				default: begin
					rresp_q <= AST_RESP_SLVERR;
				end
			endcase
		end else if (rvalid_q && s_axi_rready) begin
			arready_q <= 1'b1;
			rvalid_q  <= 1'b0;
		end
	end

	assign s_axi_awready = awready_q;
	assign s_axi_wready  = wready_q;
	assign s_axi_bvalid  = bvalid_q;
	assign s_axi_bresp   = bresp_q;
	assign s_axi_arready = arready_q;
	assign s_axi_rvalid  = rvalid_q;
	assign s_axi_rresp   = rresp_q;
	assign s_axi_rdata   = rdata_q;

endmodule

// file: ast_pkg.sv
// constants and types shared by the converter sequencer
// Function
// - the two-bit reference select field picks the conversion reference source.
// - interrupt reaches the cpu only with global and converter enables set.
// - start goes low-high-low; high resets the converter, falling edge starts it.
// - busy flag stays high during conversion, clears at completion with valid results.
// - clearing power enable switches the converter off completely.
// - results are 12-bit unsigned with full scale code fff.
// - each code stands for code times reference divided by 4096.
// - slope readable at ff5/ff6, offset bits 11-4 at ff7, 3-0 at ff8.
// - calibration table readable only while option mapping is enabled.
// - writing 0b to second control selects external input, supply reference, divide by 8.
// - writing 20 to first control powers converter on external input zero.
// - external conversion takes 4 sampling plus 12 converting clocks; with divider codes 000 and 001 the 12 steps take 48 and 48 clocks.
// - temperature conversion takes 46 sampling plus 12 converting clocks; with divider codes 000 and 001 the 12 steps take 48 and 48 clocks.
// - divider codes 000-111 give system clock over 1 to 128.
// - power enable high powers the converter; software waits before starting.
package ast_pkg;

	localparam int AST_AW    = 8;
	localparam int AST_RES_W = 12;

	// ------------------------------------------------------------
	// register offsets
	// ------------------------------------------------------------
	localparam logic [7:0] AST_OFF_CTRL1 = 8'h00;
	localparam logic [7:0] AST_OFF_CTRL2 = 8'h04;
	localparam logic [7:0] AST_OFF_RESH  = 8'h08;
	localparam logic [7:0] AST_OFF_RESL  = 8'h0c;
	localparam logic [7:0] AST_OFF_IRQ   = 8'h10;
	localparam logic [7:0] AST_OFF_OMAP  = 8'h14;
	localparam logic [7:0] AST_OFF_TADDR = 8'h18;
	localparam logic [7:0] AST_OFF_TDATA = 8'h1c;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int AST_C1_START = 7;
	localparam int AST_C1_BUSY  = 6;
	localparam int AST_C1_PWR   = 5;
	localparam int AST_C2_SRC   = 5;
	localparam int AST_C2_REF   = 3;
	localparam int AST_C2_DIV   = 0;
	localparam int AST_IRQ_GIE  = 0;
	localparam int AST_IRQ_IE   = 1;
	localparam int AST_IRQ_FLAG = 2;

	// ------------------------------------------------------------
	// reset values and codes
	// ------------------------------------------------------------
	localparam logic [7:0]  AST_RST_CTRL1 = 8'h00;
	localparam logic [7:0]  AST_RST_CTRL2 = 8'h00;
	localparam logic [11:0] AST_RST_TADDR = 12'h000;
	localparam logic [2:0]  AST_SRC_EXT   = 3'h0;
	localparam logic [2:0]  AST_SRC_TEMP  = 3'h1;
	localparam logic [11:0] AST_SAR_INIT  = 12'h800;
	localparam logic [3:0]  AST_SAR_TOP   = 4'hb;
	localparam logic [11:0] AST_CAL_SLOPE_H = 12'hff5;
	localparam logic [11:0] AST_CAL_SLOPE_L = 12'hff6;
	localparam logic [11:0] AST_CAL_TOS_H   = 12'hff7;
	localparam logic [11:0] AST_CAL_TOS_L   = 12'hff8;

	// ------------------------------------------------------------
	// timing counts in conversion clocks / system clocks
	// ------------------------------------------------------------
	localparam logic [5:0] AST_SAMPLE_EXT  = 6'h04;
	localparam logic [5:0] AST_SAMPLE_TEMP = 6'h2e;
	localparam logic [1:0] AST_SETTLE      = 2'h3;

	typedef enum logic [1:0] {AST_RESP_OKAY = 2'h0, AST_RESP_SLVERR = 2'h2} ast_resp_t;

	typedef enum {AST_R_CTRL1, AST_R_CTRL2, AST_R_RESH, AST_R_RESL, AST_R_IRQ,
		AST_R_OMAP, AST_R_TADDR, AST_R_TDATA, AST_R_NONE} ast_reg_t;

	typedef enum {AST_IDLE, AST_SAMPLE, AST_CONVERT} ast_state_t;

	typedef struct packed {
		logic        power;
		logic        sample;
		logic [1:0]  ref_voltage_select;
		logic [2:0]  input_source_select;
		logic [3:0]  ext_channel_select;
		logic [11:0] dac_code;
	} ast_analog_t;

endpackage

// file: ast_clkdiv.sv
// conversion clock tick generator
`timescale 1ns/1ps
module ast_clkdiv
	import ast_pkg::*;
(
	// clock and reset
	input  wire logic       aclk,
	input  wire logic       aresetn,
	// control
	input  wire logic       run,
	input  wire logic [2:0] conv_clock_divider,
	// tick
	output logic            tick_q
);

	logic [6:0] cnt_q;
	logic [6:0] limit;

	assign limit = 7'((8'h01 << conv_clock_divider) - 8'h01);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_q  <= 7'h00;
			tick_q <= 1'b0;
		end else if (!run) begin
			cnt_q  <= 7'h00;
			tick_q <= 1'b0;
		end else if (cnt_q >= limit) begin
			cnt_q  <= 7'h00;
			tick_q <= 1'b1;
		end else begin
			cnt_q  <= cnt_q + 7'h01;
			tick_q <= 1'b0;
		end
	end

endmodule

// file: ast_sar.sv
// successive approximation register, one bit per step
`timescale 1ns/1ps
module ast_sar
	import ast_pkg::*;
(
	// clock and reset
	input  wire logic                 aclk,
	input  wire logic                 aresetn,
	// control
	input  wire logic                 load,
	input  wire logic                 step,
	input  wire logic                 comp,
	// trial code and completion
	output logic [AST_RES_W-1:0]      code_q,
	output logic                      done_q
);

	logic [3:0]           bit_q;
	logic [AST_RES_W-1:0] code_d;

	// comparator high keeps the trial bit, low drops it
	always_comb begin
		code_d = code_q;
		if (!comp) begin
			code_d[bit_q] = 1'b0;
		end
		if (bit_q != 4'h0) begin
			code_d[bit_q - 4'h1] = 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			code_q <= 12'h000;
			bit_q  <= 4'h0;
			done_q <= 1'b0;
		end else if (load) begin
			code_q <= AST_SAR_INIT;
			bit_q  <= AST_SAR_TOP;
			done_q <= 1'b0;
		end else if (step) begin
			code_q <= code_d;
			bit_q  <= (bit_q != 4'h0) ? bit_q - 4'h1 : 4'h0;
			done_q <= (bit_q == 4'h0);
		end else begin
			done_q <= 1'b0;
		end
	end

endmodule

// file: ast_asserts.sv
// concurrent checks on the converter sequencer ports
`timescale 1ns/1ps
module ast_asserts
	import ast_pkg::*;
(
	// clock and reset
	input wire logic        aclk,
	input wire logic        aresetn,
	// register bus handshakes
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	// analog side and interrupt
	input wire ast_analog_t ana_ctrl,
	input wire logic        conv_irq
);
	// ------------------------------------------------------------
	// properties
	// ------------------------------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_wr_both;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_samp_start;
		$rose(ana_ctrl.sample);
	endsequence

	// both halves taken at one edge: wr_fire the next cycle, bvalid seen one edge later
	property p_wr_resp; s_wr_both |-> ##2 s_axi_bvalid; endproperty
	property p_b_stand; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
	property p_rd_ans; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
	property p_r_stand;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	property p_ana_wr;
		$changed({ana_ctrl.power, ana_ctrl.ref_voltage_select, ana_ctrl.input_source_select,
			ana_ctrl.ext_channel_select}) |-> $past(s_axi_bvalid);
	endproperty
	property p_samp_ext; s_samp_start |-> ana_ctrl.sample[*4]; endproperty
	property p_samp_temp;
		s_samp_start ##0 (ana_ctrl.input_source_select == AST_SRC_TEMP) |-> ana_ctrl.sample[*8];
	endproperty
	property p_samp_pwr; !ana_ctrl.power |=> !ana_ctrl.sample; endproperty
	property p_irq_fall; $fell(conv_irq) |-> $past(s_axi_bvalid); endproperty

	a_wr_resp: assert property (p_wr_resp) else $error("write response missing");
	a_b_stand: assert property (p_b_stand) else $error("write response dropped");
	a_rd_ans: assert property (p_rd_ans) else $error("read answer missing");
	a_r_stand: assert property (p_r_stand) else $error("read answer dropped");
	a_ana_wr: assert property (p_ana_wr) else $error("analog setup changed alone");
	a_samp_ext: assert property (p_samp_ext) else $error("sampling too short");
	a_samp_temp: assert property (p_samp_temp) else $error("sensor sampling short");
	a_samp_pwr: assert property (p_samp_pwr) else $error("sampling while off");
	a_irq_fall: assert property (p_irq_fall) else $error("interrupt fell alone");
endmodule

// file: tb_top.sv
// self-checking bench for the converter sequencer
`timescale 1ns/1ps
module tb_top;
	import ast_pkg::*;
	localparam logic [15:0] SLP = 16'h0ab9;
	localparam logic [11:0] TOS = 12'h407;
	logic        aclk = 0;
	logic        aresetn = 0;
	logic [7:0]  awaddr = 0;
	logic [7:0]  araddr = 0;
	logic [31:0] wdata = 0;
	logic [31:0] rdata;
	logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic        awready, wready, bvalid, arready, rvalid, irq;
	logic [1:0]  bresp, rresp, lr;
	logic [11:0] tgt = 0;
	ast_analog_t ana;
	wire         comp = tgt >= ana.dac_code;
	int          mismatches = 0, n_checks = 0, cyc = 0;

	always #25 aclk = ~aclk;
	always @(posedge aclk) cyc <= cyc + 1;

	ast_top #(.CAL_SLOPE(SLP), .CAL_TOS(TOS)) dut_u (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .ana_ctrl(ana), .comp_in(comp), .conv_irq(irq));

	// ------------------------------------------------------------
	// bus and compare tasks
	// ------------------------------------------------------------
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		n_checks++;
		if (s !== e) begin
			mismatches++;
			$display("mismatch at %0t: got %h exp %h", $time, s, e);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		chk({30'h0, bresp}, {30'h0, er});
		bready <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		d = rdata;
		lr = rresp;
		rready <= 1'b0;
	endtask

	task automatic conv(input logic [7:0] c1, output int n);
		logic [31:0] d;
		int t0;
		wr(AST_OFF_CTRL1, {24'h0, c1 | 8'h80}, 2'h0);
		wr(AST_OFF_CTRL1, {24'h0, c1}, 2'h0);
		t0 = cyc;
		rd(AST_OFF_CTRL1, d);
		chk(d, {24'h0, c1 | 8'h40});
		do rd(AST_OFF_CTRL1, d); while (d[6] !== 1'b0 && cyc < t0 + 2000);
		n = cyc - t0;
		chk(d, {24'h0, c1});
	endtask

	task automatic test_done;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_reset;
		logic [31:0] d;
		rd(AST_OFF_CTRL1, d);
		chk(d, 32'h0);
		rd(AST_OFF_CTRL2, d);
		chk(d, 32'h0);
		rd(8'h20, d);
		chk({d[31:2], lr}, 32'h2);
		wr(8'h20, 32'h1, 2'h2);
		wr(8'h02, 32'h1, 2'h2);
	endtask

	task automatic t_ext;
		logic [31:0] d;
		int n;
		wr(AST_OFF_CTRL2, 32'h0b, 2'h0);
		wr(AST_OFF_CTRL1, 32'h20, 2'h0);
		rd(AST_OFF_CTRL2, d);
		chk(d, 32'h0b);
		chk({ana.power, ana.ref_voltage_select, ana.input_source_select,
			ana.ext_channel_select}, 32'h280);
		repeat (10) @(posedge aclk);
		tgt <= 12'hfff;
		conv(8'h20, n);
		chk(32'(n >= 128 && n <= 150), 32'h1);
		rd(AST_OFF_RESH, d);
		chk(d, 32'hff);
		rd(AST_OFF_RESL, d);
		chk(d, 32'hf0);
	endtask

	task automatic t_temp;
		logic [31:0] d;
		logic [7:0] c[4];
		logic [31:0] p;
		int n;
		wr(AST_OFF_CTRL1, 32'h28, 2'h0);
		wr(AST_OFF_CTRL2, 32'h22, 2'h0);
		tgt <= 12'h514;
		conv(8'h28, n);
		chk(32'(n >= 232 && n <= 260), 32'h1);
		chk({ana.input_source_select, ana.ext_channel_select}, 32'h18);
		rd(AST_OFF_RESH, d);
		chk(d, 32'h51);
		rd(AST_OFF_RESL, d);
		chk(d, 32'h40);
		wr(AST_OFF_TADDR, 32'hff5, 2'h0);
		rd(AST_OFF_TDATA, d);
		chk(d, 32'h0);
		wr(AST_OFF_OMAP, 32'h1, 2'h0);
		for (int i = 0; i < 4; i++) begin
			wr(AST_OFF_TADDR, {20'h0, AST_CAL_SLOPE_H + 12'(i)}, 2'h0);
			rd(AST_OFF_TDATA, d);
			c[i] = d[7:0];
		end
		chk({c[0], c[1], c[2], c[3]}, {SLP, TOS[11:4], 4'h0, TOS[3:0]});
		p = {16'h0, c[0], c[1]} * {20'h0, 12'h514};
		chk({20'h0, p[23:12] - {c[2], c[3][3:0]}}, 32'hf60);
	endtask

	task automatic t_irq;
		logic [31:0] d;
		rd(AST_OFF_IRQ, d);
		chk(d, 32'h4);
		chk({31'h0, irq}, 32'h0);
		wr(AST_OFF_IRQ, 32'h7, 2'h0);
		repeat (2) @(posedge aclk);
		chk({31'h0, irq}, 32'h1);
		wr(AST_OFF_IRQ, 32'h6, 2'h0);
		repeat (2) @(posedge aclk);
		chk({31'h0, irq}, 32'h0);
		wr(AST_OFF_IRQ, 32'h5, 2'h0);
		repeat (2) @(posedge aclk);
		chk({31'h0, irq}, 32'h0);
		wr(AST_OFF_IRQ, 32'h3, 2'h0);
		repeat (2) @(posedge aclk);
		chk({31'h0, irq}, 32'h0);
		rd(AST_OFF_IRQ, d);
		chk(d, 32'h3);
	endtask

	task automatic t_abort;
		logic [31:0] d;
		tgt <= 12'h123;
		wr(AST_OFF_CTRL1, 32'ha8, 2'h0);
		wr(AST_OFF_CTRL1, 32'h28, 2'h0);
		repeat (20) @(posedge aclk);
		wr(AST_OFF_CTRL1, 32'h08, 2'h0);
		rd(AST_OFF_CTRL1, d);
		chk(d, 32'h08);
		chk({ana.power, ana.sample}, 32'h0);
		rd(AST_OFF_RESH, d);
		chk(d, 32'h51);
		rd(AST_OFF_IRQ, d);
		chk(d, 32'h3);
	endtask

	initial begin
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset;
		t_ext;
		t_temp;
		t_irq;
		t_abort;
		test_done;
	end

	initial begin
		repeat (20000) @(posedge aclk);
		mismatches++;
		test_done;
	end
endmodule

bind ast_top ast_asserts u_chk (.aclk(aclk), .aresetn(aresetn),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
	.ana_ctrl(ana_ctrl), .conv_irq(conv_irq));
